// ===== rtl/dipcfg_cfg.svh
// Constants for the switch-driven Ethernet and IP address configuration block.
// Assumes a single 250 MHz clock; included by bare name.
`ifndef DIPCFG_CFG_SVH
`define DIPCFG_CFG_SVH

// Register indices and field positions
`define DIPCFG_REG_IP_LOW_PAIR   1'h0
`define DIPCFG_REG_IP_THIRD_BYTE 1'h1
`define DIPCFG_LO_BYTE_MSB       7
`define DIPCFG_HI_BYTE_LSB       8

// Address table reset values: first, second and third byte
`define DIPCFG_IP_BYTE1_RST      8'hAC
`define DIPCFG_IP_BYTE2_RST      8'h10
`define DIPCFG_IP_BYTE3_RST      8'h11

// Link parameters reset to 100 MBaud, auto-rate on, full duplex
`define DIPCFG_LINK_RST          3'h7

// Switch positions (zero based)
`define DIPCFG_SW_SPEED          0
`define DIPCFG_SW_AUTO           1
`define DIPCFG_SW_DUPLEX         2
`define DIPCFG_SW_BOOTP          8
`define DIPCFG_SW_COMMIT         9

// Echo request payload length that binds a new address
`define DIPCFG_ECHO_LEN          16'h007B

// Class boundaries on the first address byte
`define DIPCFG_A_LO              8'h01
`define DIPCFG_A_HI              8'h7E
`define DIPCFG_B_LO              8'h80
`define DIPCFG_B_HI              8'hBF
`define DIPCFG_C_LO              8'hC0
`define DIPCFG_C_HI              8'hDF

// Timing: clock rate, LED flash time and switch settle time
`define DIPCFG_CLK_KHZ           250000
`define DIPCFG_FLASH_MS          100
`define DIPCFG_SETTLE_CYC        8'h10

`endif

// ===== rtl/dipcfg_pkg.sv
// Types shared by the configuration block and its class decoder.
// Assumes nothing of its surroundings.
package dipcfg_pkg;

    // Network class of an address
    typedef enum logic [1:0] {
        DIPCFG_CLASS_NONE,
        DIPCFG_CLASS_A,
        DIPCFG_CLASS_B,
        DIPCFG_CLASS_C
    } dipcfg_class_t;

    // Address source chosen at power-up
    typedef enum logic [2:0] {
        DIPCFG_SRC_SWITCH,
        DIPCFG_SRC_ARP,
        DIPCFG_SRC_BOOTP_STATIC,
        DIPCFG_SRC_BOOTP_DYN,
        DIPCFG_SRC_SETUP
    } dipcfg_src_t;

    // Sequencer states
    typedef enum logic [2:0] {
        DIPCFG_ST_SETTLE,
        DIPCFG_ST_DECIDE,
        DIPCFG_ST_SETUP,
        DIPCFG_ST_BOOTP,
        DIPCFG_ST_RUN
    } dipcfg_state_t;

endpackage

// ===== rtl/dipcfg_class.sv
// Network class decoder for one address.
// Assumes the first address byte arrives from logic on the same clock.
`timescale 1ns/1ps
`include "dipcfg_cfg.svh"

module dipcfg_class (
    input  wire logic [7:0]           first_byte,
    output dipcfg_pkg::dipcfg_class_t ip_class
);

    // Leading-bit classes; 0, 127 and 224 upward have no class here
    always_comb begin
        if (first_byte >= `DIPCFG_A_LO && first_byte <= `DIPCFG_A_HI) begin
            ip_class = dipcfg_pkg::DIPCFG_CLASS_A;
        end else if (first_byte >= `DIPCFG_B_LO && first_byte <= `DIPCFG_B_HI) begin
            ip_class = dipcfg_pkg::DIPCFG_CLASS_B;
        end else if (first_byte >= `DIPCFG_C_LO && first_byte <= `DIPCFG_C_HI) begin
            ip_class = dipcfg_pkg::DIPCFG_CLASS_C;
        end else begin
            ip_class = dipcfg_pkg::DIPCFG_CLASS_NONE;
        end
    end

endmodule // dipcfg_class

// ===== rtl/dipcfg_top.sv
// Power-up Ethernet link and IP address configuration from ten switches.
// Assumes external non-volatile storage presents its contents from reset
// and accepts one-cycle write strobes; echo and BootP events are same-clock.
`timescale 1ns/1ps
`include "dipcfg_cfg.svh"

module dipcfg_top #(
    parameter int unsigned FLASH_CYCLES = `DIPCFG_FLASH_MS * `DIPCFG_CLK_KHZ
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [9:0]            dip_sw,
    input  wire logic                  end_only,
    input  wire logic                  sw_reset,
    input  wire logic                  reg_sel,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [15:0]           reg_wdata,
    output logic      [15:0]           reg_rdata_r,
    input  wire logic [23:0]           nv_tbl,
    input  wire logic                  nv_tbl_ok,
    input  wire logic [31:0]           nv_arp_ip,
    input  wire logic                  nv_arp_ok,
    input  wire logic [31:0]           nv_boot_ip,
    input  wire logic                  nv_boot_ok,
    input  wire logic [2:0]            nv_link,
    input  wire logic                  nv_link_ok,
    output logic                       nv_tbl_wr_r,
    output logic      [23:0]           nv_tbl_data_r,
    output logic                       nv_arp_wr_r,
    output logic                       nv_boot_wr_r,
    output logic      [31:0]           nv_ip_data_r,
    output logic                       nv_link_wr_r,
    output logic      [2:0]            nv_link_data_r,
    input  wire logic                  echo_valid,
    input  wire logic [31:0]           echo_dst_ip,
    input  wire logic [15:0]           echo_len,
    output logic                       bootp_req_r,
    input  wire logic                  bootp_ack,
    input  wire logic [31:0]           bootp_ip,
    output logic      [31:0]           ip_addr_r,
    output logic                       ip_valid_r,
    output dipcfg_pkg::dipcfg_class_t  ip_class_r,
    output dipcfg_pkg::dipcfg_src_t    ip_src_r,
    output logic                       link_100m_r,
    output logic                       link_auto_r,
    output logic                       link_full_r,
    output logic                       led_run_r,
    output logic                       led_err_r
);

    // Three-stage synchronisers for the switch and terminal pins
    logic [10:0]                sync1_r;
    logic [10:0]                sync2_r;
    logic [10:0]                sync3_r;
    logic [10:0]                pins_r;
    logic [9:0]                 sw;
    logic                       sw_end_only;
    logic                       commit_prev_r;

    // Sequencing and power-up snapshot
    dipcfg_pkg::dipcfg_state_t  state_r;
    logic [7:0]                 settle_r;
    logic [9:0]                 sw_snap_r;

    // Address table and ARP candidate
    logic [7:0]                 byte1_r;
    logic [7:0]                 byte2_r;
    logic [7:0]                 byte3_r;
    dipcfg_pkg::dipcfg_class_t  cur_class;
    dipcfg_pkg::dipcfg_class_t  new_class;
    logic                       arp_take;

    // LED timing
    logic [31:0]                flash_cnt_r;
    logic                       flash_on_r;
    logic                       arp_flash_r;

    // Link reset pattern {speed, auto-rate, duplex}; sliced so no bits are dropped
    localparam logic [2:0]      LINK_RST = `DIPCFG_LINK_RST;

    assign sw          = pins_r[9:0];
    assign sw_end_only = pins_r[10];

    // Pin change is accepted once the second and third stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 11'h000;
            sync2_r <= 11'h000;
            sync3_r <= 11'h000;
            pins_r  <= 11'h000;
        end else begin
            sync1_r <= {end_only, dip_sw};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (int i = 0; i < 11; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    pins_r[i] <= sync3_r[i];
                end
            end
        end
    end

    // Class of the running address and of an echo target
    dipcfg_class u_cur_class (
        .first_byte (ip_addr_r[31:24]),
        .ip_class   (cur_class)
    );

    dipcfg_class u_new_class (
        .first_byte (echo_dst_ip[31:24]),
        .ip_class   (new_class)
    );

    // Echo binding: exact length, same non-empty class, switch-off mode only
    assign arp_take = (state_r == dipcfg_pkg::DIPCFG_ST_RUN)
                    && (ip_src_r == dipcfg_pkg::DIPCFG_SRC_SWITCH
                        || ip_src_r == dipcfg_pkg::DIPCFG_SRC_ARP)
                    && !sw_snap_r[`DIPCFG_SW_BOOTP] && !sw_snap_r[`DIPCFG_SW_COMMIT]
                    && echo_valid
                    && (echo_len == `DIPCFG_ECHO_LEN)
                    && (echo_dst_ip != ip_addr_r)
                    && (new_class == cur_class)
                    && (cur_class != dipcfg_pkg::DIPCFG_CLASS_NONE);

    // Startup sequencer: settle, snapshot once, then hold the decision
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= dipcfg_pkg::DIPCFG_ST_SETTLE;
            settle_r  <= 8'h00;
            sw_snap_r <= 10'h000;
            ip_src_r  <= dipcfg_pkg::DIPCFG_SRC_SWITCH;
        end else begin
            unique case (state_r)
                dipcfg_pkg::DIPCFG_ST_SETTLE: begin
                    // Wait for the synchronisers to fill before trusting pins
                    settle_r <= settle_r + 8'h01;
                    if (settle_r == `DIPCFG_SETTLE_CYC) begin
                        state_r   <= dipcfg_pkg::DIPCFG_ST_DECIDE;
                        sw_snap_r <= sw;
                    end
                end
                dipcfg_pkg::DIPCFG_ST_DECIDE: begin
                    if (sw_end_only && sw_snap_r == 10'h000) begin
                        ip_src_r <= dipcfg_pkg::DIPCFG_SRC_SETUP;
                        state_r  <= dipcfg_pkg::DIPCFG_ST_SETUP;
                    end else if (sw_snap_r[`DIPCFG_SW_BOOTP]) begin
                        if (sw_snap_r[7:0] == 8'hFF) begin
                            ip_src_r <= dipcfg_pkg::DIPCFG_SRC_BOOTP_STATIC;
                            state_r  <= nv_boot_ok ? dipcfg_pkg::DIPCFG_ST_RUN
                                                   : dipcfg_pkg::DIPCFG_ST_BOOTP;
                        end else begin
                            ip_src_r <= dipcfg_pkg::DIPCFG_SRC_BOOTP_DYN;
                            state_r  <= dipcfg_pkg::DIPCFG_ST_BOOTP;
                        end
                    end else if (!sw_snap_r[`DIPCFG_SW_COMMIT] && nv_arp_ok) begin
                        ip_src_r <= dipcfg_pkg::DIPCFG_SRC_ARP;
                        state_r  <= dipcfg_pkg::DIPCFG_ST_RUN;
                    end else begin
                        ip_src_r <= dipcfg_pkg::DIPCFG_SRC_SWITCH;
                        state_r  <= dipcfg_pkg::DIPCFG_ST_RUN;
                    end
                end
                dipcfg_pkg::DIPCFG_ST_SETUP: begin
                    // Setup stays until power is removed
                    state_r <= dipcfg_pkg::DIPCFG_ST_SETUP;
                end
                dipcfg_pkg::DIPCFG_ST_BOOTP: begin
                    if (bootp_ack) begin
                        state_r <= dipcfg_pkg::DIPCFG_ST_RUN;
                    end
                end
                dipcfg_pkg::DIPCFG_ST_RUN: begin
                    if (arp_take) begin
                        ip_src_r <= dipcfg_pkg::DIPCFG_SRC_ARP;
                    end
                end
            endcase
        end
    end

    // Address table: defaults, then stored copy, then software writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byte1_r <= `DIPCFG_IP_BYTE1_RST;
            byte2_r <= `DIPCFG_IP_BYTE2_RST;
            byte3_r <= `DIPCFG_IP_BYTE3_RST;
        end else if (state_r == dipcfg_pkg::DIPCFG_ST_SETTLE) begin
            if (nv_tbl_ok) begin
                byte1_r <= nv_tbl[23:16];
                byte2_r <= nv_tbl[15:8];
                byte3_r <= nv_tbl[7:0];
            end
        end else if (reg_wr) begin
            if (reg_sel == `DIPCFG_REG_IP_LOW_PAIR) begin
                byte1_r <= reg_wdata[`DIPCFG_LO_BYTE_MSB:0];
                byte2_r <= reg_wdata[15:`DIPCFG_HI_BYTE_LSB];
            end else begin
                byte3_r <= reg_wdata[`DIPCFG_LO_BYTE_MSB:0];
            end
        end
    end

    // Register read port; unused high byte of register 1 reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_sel == `DIPCFG_REG_IP_LOW_PAIR) begin
                reg_rdata_r <= {byte2_r, byte1_r};
            end else begin
                reg_rdata_r <= {8'h00, byte3_r};
            end
        end
    end

    // Running address; a software reset keeps it, only power clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ip_addr_r  <= 32'h0000_0000;
            ip_valid_r <= 1'b0;
        end else begin
            unique case (state_r)
                dipcfg_pkg::DIPCFG_ST_DECIDE: begin
                    if (sw_end_only && sw_snap_r == 10'h000) begin
                        ip_valid_r <= 1'b0;
                    end else if (sw_snap_r[`DIPCFG_SW_BOOTP]) begin
                        if (sw_snap_r[7:0] == 8'hFF && nv_boot_ok) begin
                            ip_addr_r  <= nv_boot_ip;
                            ip_valid_r <= 1'b1;
                        end
                    end else if (!sw_snap_r[`DIPCFG_SW_COMMIT] && nv_arp_ok) begin
                        ip_addr_r  <= nv_arp_ip;
                        ip_valid_r <= 1'b1;
                    end else begin
                        ip_addr_r  <= {byte1_r, byte2_r, byte3_r, sw_snap_r[7:0]};
                        ip_valid_r <= 1'b1;
                    end
                end
                dipcfg_pkg::DIPCFG_ST_BOOTP: begin
                    if (bootp_ack) begin
                        ip_addr_r  <= bootp_ip;
                        ip_valid_r <= 1'b1;
                    end
                end
                dipcfg_pkg::DIPCFG_ST_RUN: begin
                    if (arp_take) begin
                        ip_addr_r <= echo_dst_ip;
                    end
                end
                default: begin
                    ip_valid_r <= ip_valid_r;
                end
            endcase
        end
    end

    // Class of the running address, registered for the output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ip_class_r <= dipcfg_pkg::DIPCFG_CLASS_NONE;
        end else begin
            ip_class_r <= cur_class;
        end
    end

    // BootP request held from decision until the server answers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bootp_req_r <= 1'b0;
        end else if (state_r == dipcfg_pkg::DIPCFG_ST_BOOTP) begin
            bootp_req_r <= !bootp_ack;
        end else begin
            bootp_req_r <= 1'b0;
        end
    end

    // Link parameters: stored copy at power-up, switches on commit edge in setup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link_100m_r   <= LINK_RST[2];
            link_auto_r   <= LINK_RST[1];
            link_full_r   <= LINK_RST[0];
            commit_prev_r <= 1'b0;
        end else begin
            commit_prev_r <= sw[`DIPCFG_SW_COMMIT];
            if (state_r == dipcfg_pkg::DIPCFG_ST_SETTLE && nv_link_ok) begin
                link_100m_r <= nv_link[2];
                link_auto_r <= nv_link[1];
                link_full_r <= nv_link[0];
            end else if (state_r == dipcfg_pkg::DIPCFG_ST_SETUP
                         && sw[`DIPCFG_SW_COMMIT] && !commit_prev_r) begin
                link_100m_r <= sw[`DIPCFG_SW_SPEED];
                link_auto_r <= sw[`DIPCFG_SW_AUTO];
                link_full_r <= sw[`DIPCFG_SW_DUPLEX];
            end
        end
    end

    // Storage writes; power cycle never writes, so pending table data is lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_tbl_wr_r    <= 1'b0;
            nv_tbl_data_r  <= 24'h00_0000;
            nv_arp_wr_r    <= 1'b0;
            nv_boot_wr_r   <= 1'b0;
            nv_ip_data_r   <= 32'h0000_0000;
            nv_link_wr_r   <= 1'b0;
            nv_link_data_r <= 3'h0;
        end else begin
            nv_tbl_wr_r  <= sw_reset;
            nv_arp_wr_r  <= arp_take;
            nv_boot_wr_r <= (state_r == dipcfg_pkg::DIPCFG_ST_BOOTP) && bootp_ack
                            && (ip_src_r == dipcfg_pkg::DIPCFG_SRC_BOOTP_STATIC);
            nv_link_wr_r <= (state_r == dipcfg_pkg::DIPCFG_ST_SETUP)
                            && sw[`DIPCFG_SW_COMMIT] && !commit_prev_r;
            if (sw_reset) begin
                nv_tbl_data_r <= {byte1_r, byte2_r, byte3_r};
            end
            if (arp_take) begin
                nv_ip_data_r <= echo_dst_ip;
            end else if (state_r == dipcfg_pkg::DIPCFG_ST_BOOTP && bootp_ack) begin
                nv_ip_data_r <= bootp_ip;
            end
            nv_link_data_r <= {sw[`DIPCFG_SW_SPEED], sw[`DIPCFG_SW_AUTO],
                               sw[`DIPCFG_SW_DUPLEX]};
        end
    end

    // Flash timebase; one shared counter keeps both LEDs in step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_on_r  <= 1'b0;
        end else if (flash_cnt_r >= FLASH_CYCLES - 1) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_on_r  <= !flash_on_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
        end
    end

    // One short error flash when power-up takes a stored ARP address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arp_flash_r <= 1'b0;
        end else if (state_r == dipcfg_pkg::DIPCFG_ST_DECIDE) begin
            arp_flash_r <= !sw_snap_r[`DIPCFG_SW_BOOTP]
                           && !sw_snap_r[`DIPCFG_SW_COMMIT]
                           && !(sw_end_only && sw_snap_r == 10'h000)
                           && nv_arp_ok;
        end else if (flash_cnt_r >= FLASH_CYCLES - 1) begin
            arp_flash_r <= 1'b0;
        end
    end

    // Committed setup flags the flashing pattern
    logic setup_done_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_done_r <= 1'b0;
        end else if (state_r == dipcfg_pkg::DIPCFG_ST_SETUP
                     && sw[`DIPCFG_SW_COMMIT] && !commit_prev_r) begin
            setup_done_r <= 1'b1;
        end
    end

    // LED patterns: steady in setup, flashing once committed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            led_run_r <= 1'b0;
            led_err_r <= 1'b0;
        end else if (state_r == dipcfg_pkg::DIPCFG_ST_SETUP) begin
            led_run_r <= setup_done_r ? flash_on_r : 1'b1;
            led_err_r <= setup_done_r ? flash_on_r : 1'b1;
        end else begin
            led_run_r <= ip_valid_r;
            led_err_r <= arp_flash_r;
        end
    end

endmodule // dipcfg_top

// ===== tb/dipcfg_chk.sv
// Port checker for the switch configuration block.
// Assumes binding into dipcfg_top; sees its ports only.
`timescale 1ns/1ps
module dipcfg_chk (
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          sw_reset,
    input wire logic          echo_valid,
    input wire logic [15:0]   echo_len,
    input wire logic          bootp_req_r,
    input wire logic          bootp_ack,
    input wire logic [31:0]   bootp_ip,
    input wire logic          nv_tbl_wr_r,
    input wire logic          nv_arp_wr_r,
    input wire logic [31:0]   nv_ip_data_r,
    input wire logic [31:0]   ip_addr_r,
    input wire logic          ip_valid_r,
    input dipcfg_pkg::dipcfg_class_t ip_class_r,
    input dipcfg_pkg::dipcfg_src_t   ip_src_r,
    input wire logic          led_run_r,
    input wire logic          led_err_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    tbl_commit_a: assert property (sw_reset |=> nv_tbl_wr_r)
        else $error("table not stored");
    tbl_only_a: assert property (nv_tbl_wr_r |-> $past(sw_reset))
        else $error("table stored without reset");
    echo_len_a: assert property (echo_valid && echo_len != 16'h007B |=> !nv_arp_wr_r)
        else $error("wrong echo length taken");
    arp_store_a: assert property (nv_arp_wr_r
        |-> nv_ip_data_r == ip_addr_r && ip_src_r == dipcfg_pkg::DIPCFG_SRC_ARP)
        else $error("stored address differs");
    boot_take_a: assert property (bootp_req_r && bootp_ack
        |=> ip_valid_r && !bootp_req_r && ip_addr_r == $past(bootp_ip))
        else $error("server answer not taken");
    class_b_a: assert property (ip_addr_r[31:30] == 2'b10
        |=> ip_class_r == dipcfg_pkg::DIPCFG_CLASS_B)
        else $error("class B wrong");
    class_c_a: assert property (ip_addr_r[31:29] == 3'b110
        |=> ip_class_r == dipcfg_pkg::DIPCFG_CLASS_C)
        else $error("class C wrong");
    valid_hold_a: assert property (ip_valid_r |=> ip_valid_r)
        else $error("address dropped");
    setup_led_a: assert property (ip_src_r == dipcfg_pkg::DIPCFG_SRC_SETUP
        |-> led_run_r == led_err_r)
        else $error("setup lamps out of phase");
    cover property (nv_arp_wr_r);
    cover property (bootp_req_r && bootp_ack);
    cover property (nv_tbl_wr_r);
    cover property (ip_src_r == dipcfg_pkg::DIPCFG_SRC_SETUP && !led_run_r);
endmodule // dipcfg_chk
bind dipcfg_top dipcfg_chk chk_u (.*);

// ===== tb/dipcfg_srv.sv
// Address server model on the network side.
// Assumes the request level stays up until the answer is taken.
`timescale 1ns/1ps
module dipcfg_srv #(
    parameter logic [31:0] SRV_IP = 32'hC02D_2E2F,
    parameter int          LAT    = 3
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        bootp_req_r,
    output logic             bootp_ack,
    output logic [31:0]      bootp_ip
);
    int cnt;
    // Answers each request once, after a short think
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n || !bootp_req_r || bootp_ack) begin
            cnt       <= 0;
            bootp_ack <= 1'b0;
        end else begin
            cnt       <= cnt + 1;
            bootp_ack <= (cnt == LAT);
        end
    end
    // Address lines carry noise outside the answer cycle
    assign bootp_ip = bootp_ack ? SRV_IP : ~SRV_IP ^ 32'(cnt);
endmodule // dipcfg_srv

// ===== tb/testbench.sv
// Self-checking bench for dipcfg_top with server model and storage.
// Assumes rst_n stands for a power cycle; storage outlives it.
`timescale 1ns/1ps
module testbench;
    logic        clk, rst_n, end_only, sw_reset, reg_sel, reg_wr, reg_rd, echo_valid;
    logic        nv_tbl_ok, nv_arp_ok, nv_boot_ok, nv_link_ok, nv_tbl_wr_r, nv_arp_wr_r;
    logic        nv_boot_wr_r, nv_link_wr_r, bootp_req_r, bootp_ack, ip_valid_r, req_seen;
    logic        link_100m_r, link_auto_r, link_full_r, led_run_r, led_err_r, err_seen;
    logic [2:0]  nv_link, nv_link_data_r;
    logic [9:0]  dip_sw;
    logic [15:0] reg_wdata, reg_rdata_r, echo_len;
    logic [23:0] nv_tbl, nv_tbl_data_r;
    logic [31:0] nv_arp_ip, nv_boot_ip, nv_ip_data_r, echo_dst_ip, bootp_ip, ip_addr_r, v, e;
    dipcfg_pkg::dipcfg_class_t ip_class_r;
    dipcfg_pkg::dipcfg_src_t   ip_src_r;
    int          n_fail, num_checks, seed;
    dipcfg_top #(.FLASH_CYCLES(8)) dut_u (.*);
    dipcfg_srv srv_u (.*);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Storage keeps its contents through power loss
    always @(posedge clk) begin
        if (nv_tbl_wr_r) {nv_tbl, nv_tbl_ok} <= {nv_tbl_data_r, 1'b1};
        if (nv_arp_wr_r) {nv_arp_ip, nv_arp_ok} <= {nv_ip_data_r, 1'b1};
        if (nv_boot_wr_r) {nv_boot_ip, nv_boot_ok} <= {nv_ip_data_r, 1'b1};
        if (nv_link_wr_r) {nv_link, nv_link_ok} <= {nv_link_data_r, 1'b1};
        if (led_err_r) err_seen <= 1'b1;
        if (bootp_req_r) req_seen <= 1'b1;
    end
    // Expected switch-mode address: stored table bytes, then switches 0-7
    function automatic logic [31:0] sw_addr(input logic [23:0] t, input logic [9:0] s);
        return {t, s[7:0]};
    endfunction
    // Wide enough that flag-plus-address compares keep every bit
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Power cycle; switches settle while held in reset
    task automatic pwr(input logic [9:0] sw, input logic eo);
        {rst_n, dip_sw, end_only} = {1'b0, sw, eo};
        repeat (6) @(negedge clk);
        {rst_n, err_seen, req_seen} = 3'b100;
        repeat (45) @(negedge clk);
    endtask
    task automatic rw(input logic sel, input logic wr, input logic [15:0] d);
        {reg_sel, reg_wr, reg_rd, reg_wdata} = {sel, wr, !wr, d};
        @(negedge clk);
        {reg_wr, reg_rd} = 2'b00;
        repeat (2) @(negedge clk);
    endtask
    task automatic echo(input logic [31:0] d, input logic [15:0] n);
        {echo_valid, echo_dst_ip, echo_len} = {1'b1, d, n};
        @(negedge clk);
        echo_valid = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Whole run is near 400 cycles; this is ample margin
    initial begin
        #20000;
        n_fail++;
        results;
    end
    initial begin
        seed = 32'h751a7d99;
        {sw_reset, reg_wr, reg_rd, reg_sel, echo_valid, reg_wdata, echo_len} = '0;
        {nv_tbl_ok, nv_arp_ok, nv_boot_ok, nv_link_ok} = 4'h0;
        {echo_dst_ip, nv_tbl, nv_arp_ip, nv_boot_ip, nv_link} = '1;
        pwr(10'h0C9, 1'b0);
        chk(ip_addr_r, sw_addr(24'hAC_1011, 10'h0C9));
        chk(ip_class_r, 32'h2);
        chk(err_seen, 32'h0);
        rw(1'b0, 1'b0, 16'h0);
        chk(reg_rdata_r, 16'h10AC);
        $display("test switch address ended");
        v = $random(seed);
        e = {16'hAC10, 2'b10, v[13:0]}; // Third byte kept off the current one
        echo(e, 16'h007A);
        chk(ip_addr_r, 32'hAC10_11C9);
        echo({8'h0A, v[23:0]}, 16'h007B);
        chk(ip_addr_r, 32'hAC10_11C9);
        echo(e, 16'h007B);
        chk(ip_addr_r, e);
        pwr(10'h033, 1'b0);
        chk(ip_addr_r, e);
        chk(ip_src_r, 32'h1);
        chk(err_seen, 32'h1);
        $display("test echo address ended");
        v = $random(seed);
        rw(1'b0, 1'b1, v[15:0]);
        rw(1'b1, 1'b1, v[31:16]);
        rw(1'b1, 1'b0, 16'h0);
        chk(reg_rdata_r, {8'h00, v[23:16]});
        sw_reset = 1'b1;
        @(negedge clk);
        sw_reset = 1'b0;
        rw(1'b0, 1'b1, ~v[15:0]);
        pwr(10'h2C9, 1'b0);
        chk(ip_addr_r, sw_addr({v[7:0], v[15:8], v[23:16]}, 10'h2C9));
        $display("test table store ended");
        pwr(10'h300, 1'b0);
        chk(ip_src_r, 32'h3);
        sw_reset = 1'b1;
        @(negedge clk);
        sw_reset = 1'b0;
        repeat (3) @(negedge clk);
        chk({nv_boot_ok, ip_addr_r}, {1'b0, 32'hC02D_2E2F});
        pwr(10'h1FF, 1'b0);
        pwr(10'h1FF, 1'b0);
        chk({req_seen, ip_src_r, ip_addr_r}, {4'h2, 32'hC02D_2E2F});
        $display("test server address ended");
        pwr(10'h000, 1'b1);
        chk({led_run_r, led_err_r, link_100m_r, link_auto_r, link_full_r}, 5'h1F);
        dip_sw = {7'h40, v[2:0]};
        repeat (12) @(negedge clk);
        chk({link_100m_r, link_auto_r, link_full_r, nv_link}, {2{v[0], v[1], v[2]}});
        e[0] = led_run_r;
        repeat (8) @(negedge clk);
        chk({led_run_r, led_err_r}, {2{~e[0]}});
        $display("test setup mode ended");
        results;
    end
endmodule // testbench
